// [design/tpu_consts.vh]
// Register map, field positions, reset values and mode codes of the trace port unit
`ifndef TPU_CONSTS_VH
`define TPU_CONSTS_VH

// Register byte offsets (low 12 address bits)
`define TPU_OFS_BAUD 12'h010
`define TPU_OFS_PIN_PROTO 12'h0F0
`define TPU_OFS_FMT_STATUS 12'h300
`define TPU_OFS_FMT_CTRL 12'h304
`define TPU_OFS_TRIG_SAMPLE 12'hEE8
`define TPU_OFS_INSN_DATA 12'hEEC
`define TPU_OFS_READY_DRIVE 12'hEF0
`define TPU_OFS_INSTR_DATA 12'hEFC
`define TPU_OFS_INT_MODE 12'hF00

// Reset values
`define TPU_RST_BAUD 13'h0000
`define TPU_RST_PIN_PROTO 2'h1
`define TPU_RST_FMT_CONT 1'b1
`define TPU_RST_INT_MODE 2'h0

// Formatter status: only the unstoppable flag reads one
`define TPU_FMT_STATUS_VAL 32'h0000_0008

// Field positions
`define TPU_BAUD_W 13
`define TPU_FMT_CONT_BIT 1
`define TPU_TRIG_INS_BIT 8
`define TPU_INT_INSTR_VALID_BIT 29
`define TPU_INT_INSTR_CNT_LO 27
`define TPU_INT_INSN_VALID_BIT 26
`define TPU_INT_INSN_CNT_LO 24

// Integration mode codes
`define TPU_MODE_NORMAL 2'h0
`define TPU_MODE_ITEST 2'h1
`define TPU_MODE_IDATA 2'h2

// Pin protocol code selecting the parallel trace port
`define TPU_PROTO_TRACE_PORT 2'h0

// Source ids put beside each formatted byte
`define TPU_ID_INSN 2'h1
`define TPU_ID_INSTR 2'h2

// Integration capture depth and AXI responses
`define TPU_CAP_FULL 2'h3
`define TPU_RESP_OKAY 2'h0
`define TPU_RESP_SLVERR 2'h2

`endif

// [design/tpu_trace_port.v]
// Trace port unit: AXI4-Lite registers, formatter control, baud divider, integration capture
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
`include "tpu_consts.vh"

module tpu_trace_port #(
  parameter DATA_W = 8
) (
  input wire ref_clk_i,
  input wire sys_rst_i,
  // AXI4-Lite slave
  input wire [31:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output wire [1:0] s_axi_bresp_o,
  output wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [31:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0] s_axi_rresp_o,
  output wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // Trace reference clock pin, sampled as a level
  input wire trace_ref_clock_i,
  // Trigger pin
  input wire trigger_i,
  // Instruction trace source
  input wire insn_valid_i,
  input wire [DATA_W-1:0] insn_data_i,
  output wire insn_ready_o,
  // Instrumentation source
  input wire instr_valid_i,
  input wire [DATA_W-1:0] instr_data_i,
  output wire instr_ready_o,
  // Trace output stream
  output wire out_valid_o,
  output wire [DATA_W-1:0] out_data_o,
  output wire [1:0] out_id_o,
  output wire out_trig_o,
  input wire out_ready_i,
  // Formatter in use, and one-cycle pulse on each change of it
  output wire formatted_o,
  output wire fmt_change_o,
  // Registered output bit-rate tick, one cycle wide
  output wire baud_tick_o
);

  // Register state
  reg [`TPU_BAUD_W-1:0] baud_q; // Prescaler field
  reg [1:0] pin_proto_q; // Pin protocol selection
  reg fmt_cont_q; // Last written continuous-format enable
  reg [1:0] int_mode_q; // Integration mode field
  reg ready_drive_q; // Ready level used in test mode

  // AXI channel state
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  // Pin synchronisers; first stages feed only second stages
  reg ref_s1_q;
  reg ref_s2_q;
  reg ref_s3_q; // Edge detect stage, reads the second stage only
  reg trig_s1_q;
  reg trig_s2_q;

  // Baud divider
  reg [`TPU_BAUD_W-1:0] baud_cnt_q;
  reg baud_tick_q;

  // Output slot
  reg out_valid_q;
  reg [DATA_W-1:0] out_data_q;
  reg [1:0] out_id_q;
  reg out_trig_q;
  reg fmt_prev_q;
  reg fmt_change_q;

  // Integration capture, index 0 instruction trace, 1 instrumentation
  wire [1:0] src_valid;
  wire [2*DATA_W-1:0] src_data;
  wire [1:0] src_ready;
  wire [1:0] cap_clr;
  wire [1:0] cnt0;
  wire [1:0] cnt1;
  wire [3*DATA_W-1:0] cap0;
  wire [3*DATA_W-1:0] cap1;

  // Decoded control
  wire formatted; // Formatter in effect
  wire mode_normal;
  wire mode_itest;
  wire mode_idata;
  wire slot_free;
  wire wr_go;
  wire rd_go;
  wire [11:0] wofs;
  wire [11:0] rofs;
  wire [31:0] fmt_ctrl_rd;

  assign src_valid = {instr_valid_i, insn_valid_i};
  assign src_data = {instr_data_i, insn_data_i};

  // Trace port protocol overrides the stored enable; the stored bit is kept
  // untouched so a return to serial shows what software last wrote
  assign formatted = (pin_proto_q == `TPU_PROTO_TRACE_PORT) | fmt_cont_q;
  assign mode_normal = (int_mode_q == `TPU_MODE_NORMAL);
  assign mode_itest = (int_mode_q == `TPU_MODE_ITEST);
  assign mode_idata = (int_mode_q == `TPU_MODE_IDATA);
  assign slot_free = ~out_valid_q | out_ready_i;

  // Control read value: trigger insertion always one, enable as in effect
  assign fmt_ctrl_rd = (32'h0000_0001 << `TPU_TRIG_INS_BIT)
                     | ({31'h0000_0000, formatted} << `TPU_FMT_CONT_BIT);

  // Write address and data are taken together, one write at a time
  assign wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_q;
  assign s_axi_awready_o = wr_go;
  assign s_axi_wready_o = wr_go;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign wofs = s_axi_awaddr_i[11:0];

  // Read taken when no answer is pending
  assign rd_go = s_axi_arvalid_i & ~rvalid_q;
  assign s_axi_arready_o = ~rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign rofs = s_axi_araddr_i[11:0];

  // A read of a data register discards its own bytes and count
  assign cap_clr[0] = rd_go & (rofs == `TPU_OFS_INSN_DATA);
  assign cap_clr[1] = rd_go & (rofs == `TPU_OFS_INSTR_DATA);

  // Ready outputs per mode
  // Test mode: the software bit alone; data test: capture room; normal: slot, or at once for bypassed instruction bytes
  assign insn_ready_o = mode_itest ? ready_drive_q : src_ready[0];
  assign instr_ready_o = mode_itest ? ready_drive_q : src_ready[1];

  // Normal handshake readiness; bypass swallows instruction bytes at once
  assign src_ready[1] = mode_idata ? (cnt1 != `TPU_CAP_FULL) : (mode_normal & slot_free);
  assign src_ready[0] = mode_idata ? (cnt0 != `TPU_CAP_FULL)
                      : (mode_normal & (~formatted | (slot_free & ~instr_valid_i)));

  assign out_valid_o = out_valid_q;
  assign out_data_o = out_data_q;
  assign out_id_o = out_id_q;
  assign out_trig_o = out_trig_q;
  assign formatted_o = fmt_prev_q;
  assign fmt_change_o = fmt_change_q;
  assign baud_tick_o = baud_tick_q;

  // Integration capture per source: three bytes and a saturating count
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_cap
      reg [1:0] cnt_q;
      reg [3*DATA_W-1:0] cap_q;
      wire take;
      assign take = mode_idata & src_valid[gi] & src_ready[gi];
      // Reading clears, but a byte arriving the same cycle survives
      always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
          cnt_q <= 2'h0;
          cap_q <= {3*DATA_W{1'b0}};
        end else if (cap_clr[gi]) begin
          if (take) begin
            cnt_q <= 2'h1;
            cap_q <= {{2*DATA_W{1'b0}}, src_data[gi*DATA_W +: DATA_W]};
          end else begin
            cnt_q <= 2'h0;
            cap_q <= {3*DATA_W{1'b0}};
          end
        end else if (take) begin
          // Byte 0 lands in the low bits; ready already stops at full
          cap_q[cnt_q*DATA_W +: DATA_W] <= src_data[gi*DATA_W +: DATA_W];
          if (cnt_q != `TPU_CAP_FULL) begin
            cnt_q <= cnt_q + 2'h1;
          end
        end
      end
    end
  endgenerate

  assign cnt0 = g_cap[0].cnt_q;
  assign cnt1 = g_cap[1].cnt_q;
  assign cap0 = g_cap[0].cap_q;
  assign cap1 = g_cap[1].cap_q;

  // Pin synchronisers
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
    end else begin
      ref_s1_q <= trace_ref_clock_i;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      trig_s1_q <= trigger_i;
      trig_s2_q <= trig_s1_q;
    end
  end

  // Baud divider: one tick every prescaler+1 reference rising edges.
  // Sampling the reference clock limits it to under a quarter of our clock.
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      baud_cnt_q <= `TPU_RST_BAUD;
      baud_tick_q <= 1'b0;
    end else if (ref_s2_q & ~ref_s3_q) begin
      if (baud_cnt_q >= baud_q) begin
        baud_cnt_q <= `TPU_RST_BAUD;
        baud_tick_q <= 1'b1;
      end else begin
        baud_cnt_q <= baud_cnt_q + 13'h0001;
        baud_tick_q <= 1'b0;
      end
    end else begin
      baud_tick_q <= 1'b0;
    end
  end

  // Output slot: instrumentation first; trigger flag only when formatted
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      out_valid_q <= 1'b0;
      out_data_q <= {DATA_W{1'b0}};
      out_id_q <= 2'h0;
      out_trig_q <= 1'b0;
    end else if (~mode_normal) begin
      // Data test mode and test mode keep the trace output quiet
      out_valid_q <= 1'b0;
    end else if (slot_free) begin
      if (instr_valid_i) begin
        out_valid_q <= 1'b1;
        out_data_q <= instr_data_i;
        out_id_q <= formatted ? `TPU_ID_INSTR : 2'h0;
        out_trig_q <= formatted & trig_s2_q;
      end else if (insn_valid_i & formatted) begin
        out_valid_q <= 1'b1;
        out_data_q <= insn_data_i;
        out_id_q <= `TPU_ID_INSN;
        out_trig_q <= trig_s2_q;
      end else begin
        // Bypassed instruction bytes are taken and dropped here
        out_valid_q <= 1'b0;
      end
    end
  end

  // Flag each switch of the formatter so capture can discard around it
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      fmt_prev_q <= `TPU_RST_FMT_CONT;
      fmt_change_q <= 1'b0;
    end else begin
      fmt_prev_q <= formatted;
      fmt_change_q <= fmt_prev_q ^ formatted;
    end
  end

  // Register writes with byte enables; response OKAY or SLVERR
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      baud_q <= `TPU_RST_BAUD;
      pin_proto_q <= `TPU_RST_PIN_PROTO;
      fmt_cont_q <= `TPU_RST_FMT_CONT;
      int_mode_q <= `TPU_RST_INT_MODE;
      ready_drive_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `TPU_RESP_OKAY;
    end else begin
      if (bvalid_q & s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= `TPU_RESP_OKAY;
        if (wofs == `TPU_OFS_BAUD) begin
          if (s_axi_wstrb_i[0]) begin
            baud_q[7:0] <= s_axi_wdata_i[7:0];
          end
          if (s_axi_wstrb_i[1]) begin
            baud_q[12:8] <= s_axi_wdata_i[12:8];
          end
        end else if (wofs == `TPU_OFS_PIN_PROTO) begin
          if (s_axi_wstrb_i[0]) begin
            pin_proto_q <= s_axi_wdata_i[1:0];
          end
        end else if (wofs == `TPU_OFS_FMT_CTRL) begin
          if (s_axi_wstrb_i[0]) begin
            fmt_cont_q <= s_axi_wdata_i[`TPU_FMT_CONT_BIT];
          end
        end else if (wofs == `TPU_OFS_READY_DRIVE) begin
          if (s_axi_wstrb_i[0]) begin
            ready_drive_q <= s_axi_wdata_i[0];
          end
        end else if (wofs == `TPU_OFS_INT_MODE) begin
          if (s_axi_wstrb_i[0]) begin
            int_mode_q <= s_axi_wdata_i[1:0];
          end
        end else if ((wofs == `TPU_OFS_FMT_STATUS) || (wofs == `TPU_OFS_TRIG_SAMPLE) ||
                     (wofs == `TPU_OFS_INSN_DATA) || (wofs == `TPU_OFS_INSTR_DATA)) begin
          // Read-only registers ignore writes
          bresp_q <= `TPU_RESP_OKAY;
        end else begin
          bresp_q <= `TPU_RESP_SLVERR;
        end
      end
    end
  end

  // Register reads: answer one cycle after the address is taken
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `TPU_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= `TPU_RESP_OKAY;
      if (rofs == `TPU_OFS_BAUD) begin
        rdata_q <= {19'h0_0000, baud_q};
      end else if (rofs == `TPU_OFS_PIN_PROTO) begin
        rdata_q <= {30'h0000_0000, pin_proto_q};
      end else if (rofs == `TPU_OFS_FMT_STATUS) begin
        rdata_q <= `TPU_FMT_STATUS_VAL;
      end else if (rofs == `TPU_OFS_FMT_CTRL) begin
        rdata_q <= fmt_ctrl_rd;
      end else if (rofs == `TPU_OFS_TRIG_SAMPLE) begin
        rdata_q <= {31'h0000_0000, trig_s2_q};
      end else if (rofs == `TPU_OFS_INSN_DATA) begin
        rdata_q <= {2'h0, instr_valid_i, cnt1, insn_valid_i, cnt0, cap0};
      end else if (rofs == `TPU_OFS_INSTR_DATA) begin
        rdata_q <= {2'h0, instr_valid_i, cnt1, insn_valid_i, cnt0, cap1};
      end else if (rofs == `TPU_OFS_READY_DRIVE) begin
        // Write-only register reads as zero
        rdata_q <= 32'h0000_0000;
      end else if (rofs == `TPU_OFS_INT_MODE) begin
        rdata_q <= {30'h0000_0000, int_mode_q};
      end else begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= `TPU_RESP_SLVERR;
      end
    end else if (rvalid_q & s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// [testbench/tpu_trace_port_properties.sv]
// Port-level assertions for the trace port unit
`timescale 1ns/100ps
module tpu_props #(
  parameter DATA_W = 8
) (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire s_axi_awvalid_i,
  input wire s_axi_wvalid_i,
  input wire s_axi_bvalid_o,
  input wire s_axi_arvalid_i,
  input wire s_axi_rvalid_o,
  input wire [31:0] s_axi_rdata_o,
  input wire s_axi_rready_i,
  input wire out_valid_o,
  input wire [DATA_W-1:0] out_data_o,
  input wire [1:0] out_id_o,
  input wire out_trig_o,
  input wire out_ready_i,
  input wire formatted_o,
  input wire fmt_change_o,
  input wire baud_tick_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Steps of a register access: the request edge
  sequence s_wr_take; s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o; endsequence
  sequence s_rd_take; s_axi_arvalid_i && !s_axi_rvalid_o; endsequence
  // Answers come exactly one cycle after the request
  property p_wr_ans; s_wr_take |=> s_axi_bvalid_o; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_rd_ans; s_rd_take |=> s_axi_rvalid_o; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  // Captured read data must not move while the master stalls
  property p_rd_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  // A stalled output byte stands whole
  property p_out_hold;
    out_valid_o && !out_ready_i |=>
      out_valid_o && $stable({out_data_o, out_id_o, out_trig_o});
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output byte moved");
  // Trigger marks exist only in the formatted stream
  property p_trig; out_valid_o && out_trig_o |-> out_id_o != 2'h0; endproperty
  a_trig: assert property (p_trig) else $error("trigger on bypassed byte");
  // Each formatter switch is flagged, as a single pulse
  property p_fmt_chg; formatted_o != $past(formatted_o) |-> ##[0:1] fmt_change_o; endproperty
  a_fmt_chg: assert property (p_fmt_chg) else $error("switch not flagged");
  property p_chg_pulse; fmt_change_o |=> !fmt_change_o; endproperty
  a_chg_pulse: assert property (p_chg_pulse) else $error("switch flag too long");
  // Reference edges are at least four cycles apart, so are ticks
  property p_baud; baud_tick_o |=> !baud_tick_o [*3]; endproperty
  a_baud: assert property (p_baud) else $error("baud ticks too close");
endmodule

bind tpu_trace_port tpu_props #(.DATA_W(DATA_W)) tpu_props_i (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rready_i(s_axi_rready_i),
  .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_id_o(out_id_o),
  .out_trig_o(out_trig_o), .out_ready_i(out_ready_i), .formatted_o(formatted_o),
  .fmt_change_o(fmt_change_o), .baud_tick_o(baud_tick_o)
);

// [testbench/tpu_src_model.sv]
// Behavioural pair of trace sources feeding the trace port unit
`timescale 1ns/100ps
module tpu_src_model (
  input wire logic clk_i,
  input wire logic insn_ready_i,
  input wire logic instr_ready_i,
  output logic insn_valid_o,
  output logic [7:0] insn_data_o,
  output logic instr_valid_o,
  output logic [7:0] instr_data_o
);
  // Idle sources offer nothing
  initial begin
    insn_valid_o = 1'b0;
    insn_data_o = 8'h00;
    instr_valid_o = 1'b0;
    instr_data_o = 8'hFF;
  end
  // Offer one byte and hold it until taken; the released line shows the
  // inverse so that a stale byte cannot pass for a fresh one
  task automatic send(input bit sel, input logic [7:0] d, output bit ok);
    int n;
    n = 0;
    @(posedge clk_i);
    if (sel) begin
      instr_valid_o <= 1'b1;
      instr_data_o <= d;
    end else begin
      insn_valid_o <= 1'b1;
      insn_data_o <= d;
    end
    do begin
      @(posedge clk_i);
      n++;
      ok = sel ? instr_ready_i : insn_ready_i;
    end while (!ok && n < 100);
    if (sel) begin
      instr_valid_o <= 1'b0;
      instr_data_o <= ~d;
    end else begin
      insn_valid_o <= 1'b0;
      insn_data_o <= ~d;
    end
  endtask
endmodule

// [testbench/tb_tpu_trace_port.sv]
// Register and trace-stream tests of the trace port unit
`timescale 1ns/100ps
module tb_tpu_trace_port;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic tref = 1'b0, trig = 1'b0, ordy = 1'b0;
  wire awr, wrdy, bv, arr, rv, iv, ir, tv, tr, ov, ot, fmt, fchg, tick;
  wire [1:0] bresp, rresp, oid;
  wire [31:0] rdata;
  wire [7:0] idat, tdat, odat;
  int failures = 0, tests_run = 0, out_cnt = 0, base = 0;
  logic [10:0] last_out = '0;
  bit ok;
  // System clock, and a slow reference clock of unrelated phase
  always #10 clk = ~clk;
  initial begin
    #7;
    forever #80 tref = ~tref;
  end
  tpu_trace_port tpu_trace_port_i (
    .ref_clk_i(clk), .sys_rst_i(rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrdy),
    .trace_ref_clock_i(tref), .trigger_i(trig), .insn_valid_i(iv), .insn_data_i(idat),
    .insn_ready_o(ir), .instr_valid_i(tv), .instr_data_i(tdat), .instr_ready_o(tr),
    .out_valid_o(ov), .out_data_o(odat), .out_id_o(oid), .out_trig_o(ot),
    .out_ready_i(ordy), .formatted_o(fmt), .fmt_change_o(fchg), .baud_tick_o(tick)
  );
  tpu_src_model tpu_src_model_i (
    .clk_i(clk), .insn_ready_i(ir), .instr_ready_i(tr), .insn_valid_o(iv),
    .insn_data_o(idat), .instr_valid_o(tv), .instr_data_o(tdat)
  );
  // Sink stalls every other cycle; logs each byte it takes
  always @(posedge clk) begin
    ordy <= rst ? 1'b0 : ~ordy;
    if (ov && ordy) begin
      out_cnt <= out_cnt + 1;
      last_out <= {ot, oid, odat};
    end
  end
  task automatic print_verdict;
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // A used-up wait bound ends the run as a failure
  task automatic tmo(input bit bad);
    if (bad) begin
      failures++;
      print_verdict();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Write: address and data together, response accepted on arrival
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    awaddr <= {20'h0, a};
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      tmo(n > 60);
    end while (!awr);
    // Data channel is taken on the same edge as the address
    chk("wready", {31'h0, wrdy}, 32'h1);
    awv <= 1'b0;
    wv <= 1'b0;
    brdy <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      tmo(n > 60);
    end while (!bv);
    brdy <= 1'b0;
    // Response code is taken at the handshake edge
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  // Read: rready raised late on purpose, so the answer must stand
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    araddr <= {20'h0, a};
    arv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      tmo(n > 60);
    end while (!arr);
    arv <= 1'b0;
    do begin
      @(posedge clk);
      n++;
      tmo(n > 60);
    end while (!rv);
    rrdy <= 1'b1;
    @(posedge clk);
    rrdy <= 1'b0;
    chk(nm, rdata, e);
    chk(nm, {30'h0, rresp}, {30'h0, er});
  endtask
  task automatic put(input bit s, input logic [7:0] d);
    tpu_src_model_i.send(s, d, ok);
    tmo(!ok);
  endtask
  // Cycles between baud ticks, taken after the divider has settled
  task automatic gap(input int e);
    int n;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
        tmo(n > 300);
      end while (!tick);
    end
    chk("baud gap", n, e);
  endtask
  initial begin
    #2000000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd("baud reset", 12'h010, 32'h0);
    rd("status", 12'h300, 32'h8);
    rd("ctrl reset", 12'h304, 32'h102);
    rd("trig low", 12'hEE8, 32'h0);
    rd("unmapped", 12'h400, 32'h0, 2'h2);
    wr(12'h400, 32'h0, 2'h2);
    wr(12'h300, 32'hFFFF_FFFF);
    rd("status ro", 12'h300, 32'h8);
    wr(12'h010, 32'h2);
    gap(24);
    wr(12'h010, 32'h0);
    gap(8);
    wr(12'h010, 32'hFFFF_FFFF);
    rd("baud mask", 12'h010, 32'h1FFF);
    trig <= 1'b1;
    cyc(4);
    rd("trig high", 12'hEE8, 32'h1);
    put(1'b1, 8'h5A);
    cyc(4);
    chk("instr out", last_out, {1'b1, 2'h2, 8'h5A});
    trig <= 1'b0;
    // Let the low level pass the pin synchroniser before the next byte
    cyc(3);
    put(1'b0, 8'hC3);
    cyc(4);
    chk("insn out", last_out, {1'b0, 2'h1, 8'hC3});
    // Output around a formatter switch is not judged
    wr(12'h304, 32'h0);
    cyc(6);
    rd("ctrl off", 12'h304, 32'h100);
    chk("fmt off", {31'h0, fmt}, 32'h0);
    base = out_cnt;
    put(1'b0, 8'h11);
    cyc(4);
    chk("insn dropped", out_cnt, base);
    put(1'b1, 8'h22);
    cyc(4);
    chk("bypass out", last_out, {1'b0, 2'h0, 8'h22});
    wr(12'h0F0, 32'h0);
    cyc(6);
    rd("ctrl forced", 12'h304, 32'h102);
    chk("fmt forced", {31'h0, fmt}, 32'h1);
    put(1'b0, 8'h33);
    cyc(4);
    chk("forced out", last_out, {1'b0, 2'h1, 8'h33});
    wr(12'h0F0, 32'h1);
    rd("ctrl back", 12'h304, 32'h100);
    wr(12'h304, 32'h2);
    cyc(6);
    wr(12'hF00, 32'h1);
    chk("ready test", {ir, tr}, 2'b00);
    wr(12'hEF0, 32'h1);
    chk("ready set", {ir, tr}, 2'b11);
    rd("drive wo", 12'hEF0, 32'h0);
    wr(12'hEF0, 32'h0);
    wr(12'hF00, 32'h0);
    chk("ready normal", {ir, tr}, 2'b11);
    wr(12'hF00, 32'h2);
    base = out_cnt;
    put(1'b0, 8'hA1);
    put(1'b0, 8'hB2);
    put(1'b0, 8'hC3);
    put(1'b1, 8'hD4);
    cyc(3);
    chk("output off", out_cnt, base);
    // Fourth byte waits on a full capture until the read frees it
    fork
      put(1'b0, 8'hE5);
      begin
        cyc(1);
        rd("capture full", 12'hEEC, 32'h0FC3_B2A1);
      end
    join
    rd("capture next", 12'hEEC, 32'h0900_00E5);
    rd("instr capture", 12'hEFC, 32'h0800_00D4);
    rd("instr cleared", 12'hEFC, 32'h0);
    wr(12'hF00, 32'h0);
    print_verdict();
  end
endmodule
